// File: common/caption_pkg.sv
// constants, register map and state codes for the caption byte capture block
package caption_pkg;
   localparam int          CLK_HZ        = 20_000_000;
   localparam int          BIT_RATE_HZ   = 503_500;
   localparam int          LINE_RATE_MUL = 32;
   localparam int          BIT_CYC       = CLK_HZ / BIT_RATE_HZ;
   localparam logic [5:0]  GUARD_CYC     = 6'(BIT_CYC / 2);
   localparam logic [5:0]  GAP_MAX       = 6'h3F;

   localparam logic [7:0]  ADDR_LINE_SEL = 8'hB7;
   localparam logic [7:0]  ADDR_BYTE_ONE = 8'hD7;
   localparam logic [7:0]  ADDR_BYTE_TWO = 8'hE7;

   localparam int          LINE_FIELD_W  = 5;
   localparam logic [4:0]  LINE_FIRST    = 5'h11;
   localparam logic [4:0]  LINE_LAST     = 5'h17;
   localparam logic [4:0]  LINE_SEL_RST  = 5'h11;
   localparam logic [7:0]  BYTE_RST      = 8'h00;
   localparam logic [8:0]  LINE_CNT_MAX  = 9'h1FF;

   localparam logic [5:0]  RUNIN_BITS    = 6'h07;
   localparam logic [5:0]  START_BITS    = 6'h03;
   localparam logic [5:0]  DATA_BITS     = 6'h10;
   localparam logic [5:0]  SKIP_BITS     = 6'(RUNIN_BITS + START_BITS);
   localparam logic [5:0]  DATA_END      = 6'(SKIP_BITS + DATA_BITS);
   localparam logic [5:0]  LINE_BITS     = 6'(LINE_RATE_MUL);

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_CAPTURE = 2'b01,
      ST_DRAIN   = 2'b10
   } cap_state_e;
endpackage

// File: common/byte_fifo_if.sv
// handshake bundle between the capture logic and its byte buffer
interface byte_fifo_if #(parameter int WIDTH = 8);
   logic             push_valid;
   logic             push_ready;
   logic [WIDTH-1:0] push_data;
   logic             pop_valid;
   logic             pop_ready;
   logic [WIDTH-1:0] pop_data;
   logic             flush;
   logic             full;
   logic             empty;
   modport buffer (input push_valid, push_data, pop_ready, flush,
                   output push_ready, pop_valid, pop_data, full, empty);
   modport user   (output push_valid, push_data, pop_ready, flush,
                   input push_ready, pop_valid, pop_data, full, empty);
endinterface

// File: hw/byte_fifo.sv
// byte buffer with registered read stage, valid/ready on both sides
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic    clk,   // system clock
   input wire logic    rst,   // async reset, high
   byte_fifo_if.buffer bf     // push/pop handshake
);
   localparam int AW = $clog2(DEPTH);

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("byte_fifo: DEPTH must be a power of two >= 2");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      cnt_reg;
   logic             out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;

   wire mem_full  = (cnt_reg == (AW+1)'(DEPTH));
   wire mem_empty = (cnt_reg == '0);
   wire do_push   = bf.push_valid & ~mem_full;
   wire do_pop    = bf.pop_ready & out_valid_reg;
   wire do_load   = ~mem_empty & (~out_valid_reg | do_pop);

   assign bf.push_ready = ~mem_full;
   assign bf.pop_valid  = out_valid_reg;
   assign bf.pop_data   = out_data_reg;
   assign bf.full       = mem_full;
   assign bf.empty      = mem_empty & ~out_valid_reg;

   always_ff @(posedge clk)
   begin
      if (do_push)
         mem_reg[wr_ptr_reg] <= bf.push_data;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         cnt_reg       <= '0;
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
      end
      else if (bf.flush)
      begin
         wr_ptr_reg    <= '0;
         rd_ptr_reg    <= '0;
         cnt_reg       <= '0;
         out_valid_reg <= 1'b0;
      end
      else
      begin
         wr_ptr_reg <= do_push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
         rd_ptr_reg <= do_load ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
         cnt_reg    <= (AW+1)'(cnt_reg + do_push - do_load);
         if (do_load)
            out_data_reg <= mem_reg[rd_ptr_reg];
         if (do_load)
            out_valid_reg <= 1'b1;
         else if (do_pop)
            out_valid_reg <= 1'b0;
      end
   end

   a_fifo_count_bound: assert property (@(posedge clk) disable iff (rst)
      cnt_reg <= (AW+1)'(DEPTH))
      else $error("fifo count above depth");
   a_fifo_full_stall: assert property (@(posedge clk) disable iff (rst)
      mem_full && !bf.flush && !do_load |=> mem_full)
      else $error("full buffer lost an entry without a read");
endmodule

// File: hw/caption_line_byte_capture.sv
// caption byte capture: line select, sliced byte assembly, byte registers
module caption_line_byte_capture
   import caption_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic       clk,        // 20 MHz system clock
   input  wire logic       rst,        // async reset, high
   input  wire logic [7:0] sfr_addr,   // register address
   input  wire logic [7:0] sfr_wdata,  // register write data
   input  wire logic       sfr_wr,     // write strobe
   input  wire logic       sfr_rd,     // read strobe
   output logic      [7:0] sfr_rdata,  // read data, one cycle after strobe
   input  wire logic       field_sync, // field start level from slicer
   input  wire logic       line_sync,  // line start level from slicer
   input  wire logic       bit_clk,    // recovered bit clock, rising = bit centre
   input  wire logic       bit_data,   // sliced serial data
   output logic            caption_irq // one-cycle caption interrupt
);
   initial
   begin
      if (FIFO_DEPTH < 2)
         $error("caption capture: FIFO_DEPTH below 2");
   end

   byte_fifo_if #(.WIDTH(8)) bf ();

   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk (clk),
      .rst (rst),
      .bf  (bf.buffer)
   );

   cap_state_e  state_reg;
   cap_state_e  state_next;
   logic [3:0]  sync1_reg;
   logic [3:0]  sync2_reg;
   logic [3:0]  sync3_reg;
   logic [3:0]  stable_reg;
   logic [4:0]  line_sel_reg;
   logic [8:0]  line_cnt_reg;
   logic [5:0]  bit_idx_reg;
   logic [5:0]  gap_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  push_data_reg;
   logic        byte_pend_reg;
   logic [1:0]  got_reg;
   logic [7:0]  stage_one_reg;
   logic [7:0]  stage_two_reg;
   logic [7:0]  byte_one_reg;
   logic [7:0]  byte_two_reg;
   logic [7:0]  rdata_reg;
   logic        irq_reg;
   logic        first_bit_reg;

   // pin conditioning: a change counts once stages two and three agree
   wire  [3:0] pin_in      = {field_sync, line_sync, bit_clk, bit_data};
   wire  [3:0] agree       = ~(sync2_reg ^ sync3_reg);
   wire  [3:0] stable_next = (agree & sync2_reg) | (~agree & stable_reg);
   wire  [3:0] pin_rise    = ~stable_reg & agree & sync2_reg;
   wire        field_rise  = pin_rise[3];
   wire        line_rise   = pin_rise[2];
   wire        bit_rise    = pin_rise[1];
   wire        data_bit    = stable_reg[0];

   wire        sel_valid   = (line_sel_reg >= LINE_FIRST) &&
                             (line_sel_reg <= LINE_LAST);
   wire  [8:0] cnt_plus    = 9'(line_cnt_reg + 9'h001);
   wire        line_begin  = line_rise && !field_rise && sel_valid &&
                             (state_reg == ST_IDLE) &&
                             (cnt_plus == {4'h0, line_sel_reg});
   wire        line_finish = (line_rise || field_rise) &&
                             (state_reg == ST_CAPTURE);
   wire        stall       = byte_pend_reg && !bf.push_ready;
   wire        accept      = bit_rise && (state_reg == ST_CAPTURE) && !stall &&
                             (gap_reg >= GUARD_CYC) &&
                             (bit_idx_reg < LINE_BITS);
   wire        in_data     = (bit_idx_reg >= SKIP_BITS) &&
                             (bit_idx_reg < DATA_END);
   wire  [5:0] data_idx    = 6'(bit_idx_reg - SKIP_BITS);
   wire        byte_last   = accept && in_data && (data_idx[2:0] == 3'h7);
   wire        pop_fire    = (state_reg == ST_DRAIN) && bf.pop_valid;
   wire        drain_done  = (state_reg == ST_DRAIN) && !byte_pend_reg &&
                             bf.empty;
   wire        sel_write   = sfr_wr && (sfr_addr == ADDR_LINE_SEL);

   wire  [7:0] rd_mux      = (sfr_addr == ADDR_LINE_SEL) ? {3'h0, line_sel_reg} :
                             (sfr_addr == ADDR_BYTE_ONE) ? byte_one_reg :
                             (sfr_addr == ADDR_BYTE_TWO) ? byte_two_reg :
                             8'h00;

   assign bf.push_valid = byte_pend_reg;
   assign bf.push_data  = push_data_reg;
   assign bf.pop_ready  = (state_reg == ST_DRAIN);
   assign bf.flush      = line_begin;
   assign sfr_rdata     = rdata_reg;
   assign caption_irq   = irq_reg;

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE:    if (line_begin)  state_next = ST_CAPTURE;
         ST_CAPTURE: if (line_finish) state_next = ST_DRAIN;
         ST_DRAIN:   if (drain_done)  state_next = ST_IDLE;
         default:    state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_reg  <= 4'h0;
         sync2_reg  <= 4'h0;
         sync3_reg  <= 4'h0;
         stable_reg <= 4'h0;
         state_reg  <= ST_IDLE;
         rdata_reg  <= 8'h00;
      end
      else
      begin
         sync1_reg  <= pin_in;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         stable_reg <= stable_next;
         state_reg  <= state_next;
         if (sfr_rd)
            rdata_reg <= rd_mux;
      end
   end

   // line select and line counting
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         line_sel_reg <= LINE_SEL_RST;
         line_cnt_reg <= 9'h000;
      end
      else
      begin
         if (sel_write)
            line_sel_reg <= sfr_wdata[LINE_FIELD_W-1:0];
         if (field_rise)
            line_cnt_reg <= 9'h001;
         else if (line_rise && line_cnt_reg != LINE_CNT_MAX)
            line_cnt_reg <= cnt_plus;
      end
   end

   // bit pacing and serial-to-parallel
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bit_idx_reg   <= 6'h00;
         gap_reg       <= GAP_MAX;
         shift_reg     <= 8'h00;
         push_data_reg <= 8'h00;
         byte_pend_reg <= 1'b0;
         first_bit_reg <= 1'b0;
      end
      else
      begin
         if (line_begin)
            bit_idx_reg <= 6'h00;
         else if (accept)
            bit_idx_reg <= 6'(bit_idx_reg + 6'h01);
         if (accept)
            gap_reg <= 6'h01;
         else if (gap_reg != GAP_MAX)
            gap_reg <= 6'(gap_reg + 6'h01);
         if (accept && in_data)
            shift_reg <= {data_bit, shift_reg[7:1]};
         if (accept && bit_idx_reg == SKIP_BITS)
            first_bit_reg <= data_bit;
         if (byte_last)
            push_data_reg <= {data_bit, shift_reg[7:1]};
         if (byte_last)
            byte_pend_reg <= 1'b1;
         else if (bf.push_ready || line_begin)
            byte_pend_reg <= 1'b0;
      end
   end

   // drain buffered bytes, then load registers with the interrupt
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         got_reg       <= 2'h0;
         stage_one_reg <= BYTE_RST;
         stage_two_reg <= BYTE_RST;
         byte_one_reg  <= BYTE_RST;
         byte_two_reg  <= BYTE_RST;
         irq_reg       <= 1'b0;
      end
      else
      begin
         irq_reg <= drain_done;
         if (line_begin)
         begin
            got_reg       <= 2'h0;
            stage_one_reg <= BYTE_RST;
            stage_two_reg <= BYTE_RST;
            byte_one_reg  <= BYTE_RST;
            byte_two_reg  <= BYTE_RST;
         end
         else
         begin
            if (pop_fire && got_reg == 2'h0)
               stage_one_reg <= bf.pop_data;
            if (pop_fire && got_reg == 2'h1)
               stage_two_reg <= bf.pop_data;
            if (pop_fire && got_reg != 2'h2)
               got_reg <= 2'(got_reg + 2'h1);
            if (drain_done)
            begin
               byte_one_reg <= stage_one_reg;
               byte_two_reg <= stage_two_reg;
            end
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_line_sel_range: assert property (line_begin |->
      line_sel_reg >= 5'h11 && line_sel_reg <= 5'h17)
      else $error("capture began outside lines 17 to 23");
   a_line_binary: assert property (line_rise && !field_rise &&
      state_reg == ST_IDLE && cnt_plus == {4'h0, line_sel_reg} && sel_valid
      |=> state_reg == ST_CAPTURE)
      else $error("selected line number did not start capture");
   a_upper_bits_zero: assert property (sfr_rd && sfr_addr == ADDR_LINE_SEL
      |=> sfr_rdata[7:5] == 3'h0)
      else $error("line select upper bits read nonzero");
   a_begin_clears: assert property (line_begin |=>
      byte_one_reg == 8'h00 && byte_two_reg == 8'h00)
      else $error("byte registers not cleared at line start");
   a_load_stage_one: assert property (drain_done |=>
      byte_one_reg == $past(stage_one_reg) && caption_irq)
      else $error("first byte not loaded with interrupt");
   a_load_stage_two: assert property (drain_done |=>
      byte_two_reg == $past(stage_two_reg))
      else $error("second byte not loaded at line end");
   a_irq_with_load: assert property ($rose(caption_irq) |->
      $past(state_reg) == ST_DRAIN)
      else $error("interrupt without a byte load");
   a_irq_every_line: assert property (line_finish |-> ##[2:40] caption_irq)
      else $error("selected line ended without interrupt");
   // nothing popped during the drain means the line delivered no byte
   a_empty_zero: assert property (drain_done && got_reg == 2'h0 |=>
      byte_one_reg == 8'h00 && byte_two_reg == 8'h00)
      else $error("empty line left nonzero bytes");
   a_lsb_first: assert property (byte_last && bit_idx_reg == 6'h11 |=>
      push_data_reg[0] == first_bit_reg)
      else $error("first data bit not in bit 0");
   a_preamble_skip: assert property (accept && bit_idx_reg < 6'h0A |=>
      $stable(shift_reg))
      else $error("run-in or start bit shifted into data");
   a_bit_spacing: assert property (accept |=> !accept [*8])
      else $error("bit strobes closer than the bit period allows");

   c_two_bytes: cover property (drain_done && got_reg == 2'h2);
   c_empty_line: cover property (drain_done && got_reg == 2'h0);
   c_push_stall: cover property (byte_pend_reg && !bf.push_ready);
   c_sel_rewrite: cover property (sel_write ##[1:50] line_begin);
endmodule

// File: test/slicer_model.sv
// behavioural slicer: field, line and bit stream stimulus toward the capture block
module slicer_model (
   input  wire logic clk,        // system clock
   output logic      field_sync, // field start level
   output logic      line_sync,  // line start level
   output logic      bit_clk,    // recovered bit clock
   output logic      bit_data    // sliced data
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      field_sync = 1'b0;
      line_sync  = 1'b0;
      bit_clk    = 1'b0;
      bit_data   = 1'b0;
   end

   // released data line changes every cycle
   task automatic idle(input int n);
      repeat (n)
      begin
         @(negedge clk);
         bit_data <= ~bit_data;
      end
   endtask

   task automatic field_pulse();
      @(negedge clk);
      field_sync <= 1'b1;
      idle(8);
      field_sync <= 1'b0;
      idle(30);
   endtask

   task automatic line_pulse(input int tail);
      @(negedge clk);
      line_sync <= 1'b1;
      idle(8);
      line_sync <= 1'b0;
      idle(tail);
   endtask

   // bit i goes out i-th, data steady around each rise
   task automatic send_bits(input logic [63:0] bits, input int n, input int half);
      for (int i = 0; i < n; i++)
      begin
         @(negedge clk);
         bit_clk  <= 1'b0;
         bit_data <= bits[i];
         repeat (half) @(negedge clk);
         bit_clk <= 1'b1;
         repeat (half) @(negedge clk);
      end
      @(negedge clk);
      bit_clk <= 1'b0;
   endtask
endmodule

// File: test/caption_line_byte_capture_bench.sv
// self-checking bench: caption line capture against a queue model
`define CHK(nm, e, g) \
   begin \
      compares++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("[ERR] %s expected %h seen %h", nm, (e), (g)); \
      end \
   end

module caption_line_byte_capture_bench
   import caption_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic       clk;
   logic       rst;
   logic [7:0] sfr_addr;
   logic [7:0] sfr_wdata;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [7:0] sfr_rdata;
   logic       field_sync;
   logic       line_sync;
   logic       bit_clk;
   logic       bit_data;
   logic       caption_irq;
   logic [7:0] exp1;
   logic [7:0] exp2;
   int         mismatches;
   int         compares;
   int         irq_count;

   caption_line_byte_capture #(.FIFO_DEPTH(16)) i_caption_line_byte_capture (
      .clk         (clk),
      .rst         (rst),
      .sfr_addr    (sfr_addr),
      .sfr_wdata   (sfr_wdata),
      .sfr_wr      (sfr_wr),
      .sfr_rd      (sfr_rd),
      .sfr_rdata   (sfr_rdata),
      .field_sync  (field_sync),
      .line_sync   (line_sync),
      .bit_clk     (bit_clk),
      .bit_data    (bit_data),
      .caption_irq (caption_irq)
   );

   slicer_model i_slicer_model (
      .clk        (clk),
      .field_sync (field_sync),
      .line_sync  (line_sync),
      .bit_clk    (bit_clk),
      .bit_data   (bit_data)
   );

   always #25 clk = ~clk;

   always @(posedge clk)
      if (caption_irq === 1'b1)
         irq_count++;

   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(negedge clk);
      sfr_wr <= 1'b0;
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      @(negedge clk);
      sfr_rd <= 1'b0;
      @(negedge clk);
      d = sfr_rdata;
   endtask

   task automatic check_reg(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [7:0] v;
      sfr_read(a, v);
      `CHK(nm, e, v)
   endtask

   // one field up to and past the selected line, model built from accepted bits
   task automatic run_line(input logic [7:0] sel, input int nbits, input int half);
      logic [63:0] raw;
      logic [7:0]  e1;
      logic [7:0]  e2;
      logic [7:0]  v;
      logic        in_range;
      bit          q[$];
      int          last;
      int          c0;
      raw = {$urandom, $urandom};
      in_range = (sel[4:0] >= LINE_FIRST) && (sel[4:0] <= LINE_LAST);
      last = 0;
      e1 = 8'h00;
      e2 = 8'h00;
      for (int i = 0; i < nbits; i++)
         if (q.size() == 0 || i * (2 * half + 1) - last >= int'(GUARD_CYC))
         begin
            q.push_back(raw[i]);
            last = i * (2 * half + 1);
         end
      for (int k = 0; k < 8; k++)
      begin
         if (q.size() >= 18)
            e1[k] = q[10 + k];
         if (q.size() >= 26)
            e2[k] = q[18 + k];
      end
      sfr_write(ADDR_LINE_SEL, sel);
      check_reg(ADDR_LINE_SEL, {3'h0, sel[4:0]}, "line select");
      i_slicer_model.field_pulse();
      repeat (int'(sel[4:0]) - 1) i_slicer_model.line_pulse(30);
      if (in_range)
      begin
         check_reg(ADDR_BYTE_ONE, 8'h00, "byte one at line start");
         check_reg(ADDR_BYTE_TWO, 8'h00, "byte two at line start");
      end
      i_slicer_model.send_bits(raw, nbits, half);
      c0 = irq_count;
      fork
         i_slicer_model.line_pulse(0);
         for (int i = 0; i < 20 && irq_count == c0; i++)
         begin
            sfr_read(ADDR_BYTE_ONE, v);
            if (irq_count == c0)
               `CHK("byte one before irq", (in_range ? 8'h00 : exp1), v)
         end
      join
      repeat (10) @(negedge clk);
      `CHK("irq count", c0 + (in_range ? 1 : 0), irq_count)
      if (in_range)
      begin
         exp1 = e1;
         exp2 = e2;
      end
      check_reg(ADDR_BYTE_ONE, exp1, "byte one");
      check_reg(ADDR_BYTE_TWO, exp2, "byte two");
      $display("test select %h bits %0d done", sel, nbits);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      stop_test();
   end

   initial
   begin
      clk        = 1'b0;
      rst        = 1'b1;
      sfr_addr   = 8'h00;
      sfr_wdata  = 8'h00;
      sfr_wr     = 1'b0;
      sfr_rd     = 1'b0;
      exp1       = BYTE_RST;
      exp2       = BYTE_RST;
      mismatches = 0;
      compares   = 0;
      irq_count  = 0;
      void'($urandom(58456));
      repeat (12) @(negedge clk);
      rst <= 1'b0;
      check_reg(ADDR_LINE_SEL, {3'h0, LINE_SEL_RST}, "select reset");
      check_reg(ADDR_BYTE_ONE, BYTE_RST, "byte one reset");
      check_reg(ADDR_BYTE_TWO, BYTE_RST, "byte two reset");
      check_reg(8'hA5, 8'h00, "unmapped read");
      sfr_write(ADDR_BYTE_ONE, 8'h5A);
      check_reg(ADDR_BYTE_ONE, BYTE_RST, "byte one read only");
      $display("test register access done");
      for (int l = 17; l <= 23; l++)
         run_line({3'($urandom), 5'(l)}, 26, 20);
      run_line({3'h0, 5'h14}, 0, 20);
      run_line({3'h5, 5'h12}, 20, 20);
      run_line({3'h7, 5'h11}, 52, 6);
      run_line(8'h18, 26, 20);
      run_line(8'h10, 26, 20);
      stop_test();
   end
endmodule
